// ==== hdl/uart_regs_pkg.sv ====
// Package for one asynchronous serial channel: offsets, fields, resets.
// Assumes a 100 MHz clk; the 16x sample tick comes from the baud divisor.
package uart_regs_pkg;
   // Register offsets on the three address lines
   localparam logic [2:0] OFS_HOLD = 3'h0;
   localparam logic [2:0] OFS_IEN = 3'h1;
   localparam logic [2:0] OFS_FIFO = 3'h2;
   localparam logic [2:0] OFS_LCTL = 3'h3;
   localparam logic [2:0] OFS_MCTL = 3'h4;
   localparam logic [2:0] OFS_LSTAT = 3'h5;
   localparam logic [2:0] OFS_MSTAT = 3'h6;
   localparam logic [2:0] OFS_SCRATCH = 3'h7;
   // Reset values
   localparam logic [7:0] RST_IEN = 8'h00;
   localparam logic [7:0] RST_FCTL = 8'h00;
   localparam logic [7:0] RST_LCTL = 8'h00;
   localparam logic [7:0] RST_MCTL = 8'h00;
   localparam logic [7:0] RST_ISTAT = 8'h01;
   localparam logic [7:0] RST_LSTAT = 8'h60;
   localparam logic [7:0] RST_SCRATCH = 8'hff;
   localparam logic [15:0] RST_DIV = 16'h0001;
   // Field positions
   localparam int LCTL_DLAB = 7;
   localparam int LCTL_BREAK = 6;
   localparam int FCTL_EN = 0;
   localparam int FCTL_RXCLR = 1;
   localparam int FCTL_TXCLR = 2;
   localparam int FCTL_DMA = 3;
   localparam int MCTL_LOOP = 4;
   // Timing: start bit checked at 7.5 ticks, taken as tick 7 then half
   localparam logic [3:0] START_MID = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hf;
   localparam logic [3:0] DATA_BITS = 4'h8;
   // FIFO size
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
   // Received character with its status
   typedef struct packed {
      logic brk;
      logic frame_err;
      logic [7:0] data;
   } rx_char_s;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_e;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SHIFT = 3'b010,
      TX_STOP = 3'b100
   } tx_state_e;
endpackage

// ==== hdl/uart_skid_buf.sv ====
// Two-entry buffer with valid/ready on both sides.
// Assumes producer and consumer on the same clock.
`timescale 1ns/10ps
module uart_skid_buf
   import uart_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire rx_char_s in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output rx_char_s out_data
);
   rx_char_s slot_reg [2];
   logic [1:0] count_reg;
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic push;
   logic pop;

   // Handshake terms
   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = slot_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         slot_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_reg <= 2'h0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop)
         begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ==== hdl/uart_fifo.sv ====
// Sixteen-entry character FIFO with level and flush.
// Assumes one clock; push on a full FIFO is dropped, pop on an empty one ignored.
`timescale 1ns/10ps
module uart_fifo
   import uart_regs_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic flush,
   // Write side
   input wire logic push,
   input wire logic [WIDTH-1:0] wdata,
   // Read side
   input wire logic pop,
   output logic [WIDTH-1:0] rdata,
   // Level
   output logic [4:0] level,
   output logic full,
   output logic empty
);
   logic [WIDTH-1:0] mem [FIFO_DEPTH];
   logic [3:0] wptr_reg;
   logic [3:0] rptr_reg;
   logic [4:0] count_reg;
   logic do_push;
   logic do_pop;

   // Status terms
   assign full = (count_reg == FIFO_FULL_CNT);
   assign empty = (count_reg == 5'h00);
   assign level = count_reg;
   assign rdata = mem[rptr_reg];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   // Storage
   always_ff @(posedge clk)
   begin
      if (do_push)
      begin
         mem[wptr_reg] <= wdata;
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wptr_reg <= 4'h0;
         rptr_reg <= 4'h0;
         count_reg <= 5'h00;
      end
      else if (flush)
      begin
         wptr_reg <= 4'h0;
         rptr_reg <= 4'h0;
         count_reg <= 5'h00;
      end
      else
      begin
         if (do_push)
         begin
            wptr_reg <= wptr_reg + 4'h1;
         end
         if (do_pop)
         begin
            rptr_reg <= rptr_reg + 4'h1;
         end
         count_reg <= count_reg + {4'h0, do_push} - {4'h0, do_pop};
      end
   end
endmodule

// ==== hdl/uart_channel.sv ====
// One asynchronous serial channel: host registers, transmitter, receiver.
// Assumes host strobes are synchronous to clk; rx pin is asynchronous.
`timescale 1ns/10ps
// Behaviour
// RL1: Registers answer host access only while channel select is low.
// RL2: Divisor latch bit set maps offsets 0 and 1 to divisor bytes.
// RL3: Reset loads control 00, status 01, line status 60, scratch ff.
// RL4: Offset 0 write loads transmit holding when holding or shifter empty; code needs holding empty, or FIFO not full with FIFOs.
// RL5: Holding-empty flag sets when transmitter empties or word moves out.
// RL6: With FIFOs, empty flag reads zero only when transmit FIFO full.
// RL7: Offset 0 read returns oldest received character and removes it.
// RL8: On rx fall count 7.5 ticks, accept start only if still low.
// RL9: Line status reports ready, overrun, parity, framing, break, FIFO error; code holds parity at zero.
// RL10: High mid-sample of start is dropped; resume watching for falls.
module uart_channel
   import uart_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host bus
   input wire logic cs_n,
   input wire logic [2:0] addr,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // Serial line
   input wire logic rx_pin,
   output logic tx_pin
);
   // Host registers, strobes and decode terms
   logic [7:0] ien_reg, fctl_reg, lctl_reg, mctl_reg, scratch_reg;
   logic [7:0] rdata_reg, lstat, istat;
   logic [15:0] div_reg, baud_cnt_reg;
   logic wr_d_reg, rd_d_reg, wr_stb, rd_stb, dlab, fifo_on, tick;
   // Transmitter
   logic [7:0] tx_fifo_out, tx_shift_reg;
   logic [4:0] tx_level;
   logic [3:0] tx_tick_reg, tx_bit_reg;
   logic tx_full, tx_empty, tx_push, tx_pop, tx_reg;
   tx_state_e tx_state_reg;
   // Receiver
   logic rx_s1_reg, rx_s2_reg, rx_prev_reg, rx_line, rx_done_valid_reg;
   logic rx_buf_ready, rx_buf_valid, rx_full, rx_empty, rx_pop, rx_push;
   logic overrun_reg, fifo_err_reg;
   logic [3:0] rx_tick_reg, rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic [4:0] rx_level;
   rx_state_e rx_state_reg;
   rx_char_s rx_done_reg, rx_buf_data, rx_fifo_out;
   // Host strobes: one pulse per access, only with select low
   assign wr_stb = !cs_n && !wr_n && !wr_d_reg; // see RL1
   assign rd_stb = !cs_n && !rd_n && !rd_d_reg; // see RL1
   assign dlab = lctl_reg[LCTL_DLAB];
   assign fifo_on = fctl_reg[FCTL_EN];
   assign rdata = rdata_reg;
   assign tx_pin = tx_reg;
   // Edge memory for the host strobes
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_d_reg <= 1'b0;
         rd_d_reg <= 1'b0;
      end
      else
      begin
         wr_d_reg <= !cs_n && !wr_n;
         rd_d_reg <= !cs_n && !rd_n;
      end
   end
   // Writable control registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ien_reg <= RST_IEN; // see RL3
         fctl_reg <= RST_FCTL;
         lctl_reg <= RST_LCTL;
         mctl_reg <= RST_MCTL;
         scratch_reg <= RST_SCRATCH;
         div_reg <= RST_DIV;
      end
      else
      begin
         // Flush bits are self-clearing
         fctl_reg[FCTL_RXCLR] <= 1'b0;
         fctl_reg[FCTL_TXCLR] <= 1'b0;
         if (wr_stb)
         begin
            if (addr == OFS_HOLD && dlab)
               div_reg[7:0] <= wdata; // see RL2
            else if (addr == OFS_IEN && dlab)
               div_reg[15:8] <= wdata; // see RL2
            else if (addr == OFS_IEN)
               ien_reg <= wdata;
            else if (addr == OFS_FIFO)
               fctl_reg <= wdata[FCTL_EN] ? wdata : RST_FCTL; // Enable gates
            else if (addr == OFS_LCTL)
               lctl_reg <= wdata;
            else if (addr == OFS_MCTL)
               mctl_reg <= wdata;
            else if (addr == OFS_SCRATCH)
               scratch_reg <= wdata;
         end
      end
   end
   // 16x tick from the divisor
   assign tick = (baud_cnt_reg == 16'h0001) || (div_reg == 16'h0000);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         baud_cnt_reg <= RST_DIV;
      else if (tick)
         baud_cnt_reg <= div_reg;
      else
         baud_cnt_reg <= baud_cnt_reg - 16'h0001;
   end
   // Transmit FIFO; one entry deep when FIFOs are off
   assign tx_push = wr_stb && addr == OFS_HOLD && !dlab &&
      (fifo_on ? !tx_full : tx_empty); // see RL4
   assign tx_pop = (tx_state_reg == TX_IDLE) && !tx_empty && tick;
   uart_fifo #(.WIDTH(8)) tx_fifo (
      .clk(clk),
      .rstn(rstn),
      .flush(fctl_reg[FCTL_TXCLR]),
      .push(tx_push),
      .wdata(wdata),
      .pop(tx_pop),
      .rdata(tx_fifo_out),
      .level(tx_level),
      .full(tx_full),
      .empty(tx_empty)
   );
   // Transmit shifter: start, eight data bits, one stop
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 8'h00;
         tx_tick_reg <= 4'h0;
         tx_bit_reg <= 4'h0;
         tx_reg <= 1'b1;
      end
      else
      begin
         case (tx_state_reg)
            TX_IDLE:
            begin
               tx_reg <= !lctl_reg[LCTL_BREAK];
               if (tx_pop)
               begin
                  tx_shift_reg <= tx_fifo_out; // see RL5
                  tx_reg <= 1'b0;
                  tx_tick_reg <= 4'h0;
                  tx_bit_reg <= 4'h0;
                  tx_state_reg <= TX_SHIFT;
               end
            end
            TX_SHIFT:
            begin
               if (tick)
               begin
                  tx_tick_reg <= tx_tick_reg + 4'h1;
                  if (tx_tick_reg == TICK_LAST)
                  begin
                     tx_reg <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                     tx_bit_reg <= tx_bit_reg + 4'h1;
                     if (tx_bit_reg == DATA_BITS)
                     begin
                        tx_reg <= 1'b1;
                        tx_state_reg <= TX_STOP;
                     end
                  end
               end
            end
            TX_STOP:
            begin
               if (tick)
               begin
                  tx_tick_reg <= tx_tick_reg + 4'h1;
                  if (tx_tick_reg == TICK_LAST)
                     tx_state_reg <= TX_IDLE;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end
   // Receive pin synchroniser and edge memory
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
      end
      else
      begin
         rx_s1_reg <= rx_pin;
         rx_s2_reg <= rx_s1_reg;
         rx_prev_reg <= rx_line;
      end
   end
   assign rx_line = mctl_reg[MCTL_LOOP] ? tx_reg : rx_s2_reg; // Loop-back
   // Receive state machine
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_state_reg <= RX_IDLE;
         rx_tick_reg <= 4'h0;
         rx_bit_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         rx_done_valid_reg <= 1'b0;
         rx_done_reg <= '0;
      end
      else
      begin
         if (rx_done_valid_reg && rx_buf_ready)
            rx_done_valid_reg <= 1'b0;
         case (rx_state_reg)
            RX_IDLE:
            begin
               if (rx_prev_reg && !rx_line)
               begin
                  rx_tick_reg <= 4'h0; // see RL8
                  rx_state_reg <= RX_START;
               end
            end
            RX_START:
            begin
               if (tick)
               begin
                  rx_tick_reg <= rx_tick_reg + 4'h1;
                  if (rx_tick_reg == START_MID)
                  begin
                     if (rx_line)
                        rx_state_reg <= RX_IDLE; // see RL10
                     else
                     begin
                        rx_tick_reg <= 4'h0; // see RL8
                        rx_bit_reg <= 4'h0;
                        rx_state_reg <= RX_DATA;
                     end
                  end
               end
            end
            RX_DATA:
            begin
               if (tick)
               begin
                  rx_tick_reg <= rx_tick_reg + 4'h1;
                  if (rx_tick_reg == TICK_LAST)
                  begin
                     rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                     rx_bit_reg <= rx_bit_reg + 4'h1;
                     if (rx_bit_reg == DATA_BITS - 4'h1)
                        rx_state_reg <= RX_STOP;
                  end
               end
            end
            RX_STOP:
            begin
               if (tick)
               begin
                  rx_tick_reg <= rx_tick_reg + 4'h1;
                  if (rx_tick_reg == TICK_LAST)
                  begin
                     rx_done_reg.data <= rx_shift_reg;
                     rx_done_reg.frame_err <= !rx_line; // see RL9
                     rx_done_reg.brk <= !rx_line && (rx_shift_reg == 8'h00);
                     rx_done_valid_reg <= 1'b1;
                     rx_state_reg <= RX_IDLE;
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end
   // Buffer between the assembler and the receive FIFO
   uart_skid_buf rx_buf (
      .clk(clk),
      .rstn(rstn),
      .in_valid(rx_done_valid_reg),
      .in_ready(rx_buf_ready),
      .in_data(rx_done_reg),
      .out_valid(rx_buf_valid),
      .out_ready(rx_push),
      .out_data(rx_buf_data)
   );
   // Without FIFOs the holding register is one entry deep
   assign rx_push = rx_buf_valid && (fifo_on ? !rx_full : rx_empty);
   assign rx_pop = rd_stb && addr == OFS_HOLD && !dlab; // see RL7
   uart_fifo #(.WIDTH(10)) rx_fifo (
      .clk(clk),
      .rstn(rstn),
      .flush(fctl_reg[FCTL_RXCLR]),
      .push(rx_push),
      .wdata(rx_buf_data),
      .pop(rx_pop),
      .rdata(rx_fifo_out),
      .level(rx_level),
      .full(rx_full),
      .empty(rx_empty)
   );
   // Sticky overrun and FIFO-error bits; setting wins over read clear
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         overrun_reg <= 1'b0;
         fifo_err_reg <= 1'b0;
      end
      else
      begin
         if (rx_buf_valid && !rx_push && !rx_buf_ready)
            overrun_reg <= 1'b1; // see RL9
         else if (rd_stb && addr == OFS_LSTAT)
            overrun_reg <= 1'b0;
         if (rx_push && fifo_on &&
            (rx_buf_data.frame_err || rx_buf_data.brk))
            fifo_err_reg <= 1'b1;
         else if (rd_stb && addr == OFS_LSTAT)
            fifo_err_reg <= 1'b0;
      end
   end
   // Line status assembly; parity is not generated so stays zero
   assign lstat = {fifo_err_reg, tx_empty && (tx_state_reg == TX_IDLE),
      (fifo_on ? !tx_full : tx_empty), !rx_empty && rx_fifo_out.brk,
      !rx_empty && rx_fifo_out.frame_err, 1'b0, overrun_reg,
      !rx_empty}; // see RL5 RL6 RL9
   assign istat = {fifo_on, fifo_on, RST_ISTAT[5:0]};
   // Read data, registered on each read strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_reg <= 8'h00;
      else if (rd_stb)
      begin
         if (addr == OFS_HOLD && dlab)
            rdata_reg <= div_reg[7:0]; // see RL2
         else if (addr == OFS_IEN && dlab)
            rdata_reg <= div_reg[15:8];
         else if (addr == OFS_HOLD)
            rdata_reg <= rx_fifo_out.data; // see RL7
         else if (addr == OFS_IEN)
            rdata_reg <= ien_reg;
         else if (addr == OFS_FIFO)
            rdata_reg <= istat;
         else if (addr == OFS_LCTL)
            rdata_reg <= lctl_reg;
         else if (addr == OFS_MCTL)
            rdata_reg <= mctl_reg;
         else if (addr == OFS_LSTAT)
            rdata_reg <= lstat;
         else if (addr == OFS_MSTAT)
            rdata_reg <= 8'h00;
         else
            rdata_reg <= scratch_reg;
      end
   end
endmodule

// ==== verification/uart_channel_chk.sv ====
// Checker for one serial channel: host reads, reset state, tx framing.
// Assumes it is bound to uart_channel and sees only its ports.
`timescale 1ns/10ps
module uart_channel_chk
   import uart_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host bus
   input wire logic cs_n,
   input wire logic [2:0] addr,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   // Serial line
   input wire logic rx_pin,
   input wire logic tx_pin
);
   logic wr_prev;
   logic rd_prev;
   logic wr_take;
   logic rd_take;
   logic [7:0] scr_shadow;
   logic [7:0] lctl_shadow;
   logic [7:0] dll_shadow;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // An access is taken on the first cycle of its strobe
   assign wr_take = !cs_n && !wr_n && !wr_prev;
   assign rd_take = !cs_n && !rd_n && !rd_prev;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_prev <= 1'b0;
         rd_prev <= 1'b0;
      end
      else
      begin
         wr_prev <= !cs_n && !wr_n;
         rd_prev <= !cs_n && !rd_n;
      end
   end
   // Shadow copies of the plain read/write registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scr_shadow <= 8'hff;
         lctl_shadow <= 8'h00;
         dll_shadow <= RST_DIV[7:0];
      end
      else if (wr_take)
      begin
         if (addr == OFS_SCRATCH)
            scr_shadow <= wdata;
         if (addr == OFS_LCTL)
            lctl_shadow <= wdata;
         if (addr == OFS_HOLD && lctl_shadow[LCTL_DLAB])
            dll_shadow <= wdata;
      end
   end
   sequence s_read(logic [2:0] ofs);
      rd_take && addr == ofs;
   endsequence
   sequence s_tx_start;
      $fell(tx_pin);
   endsequence
   a_reset_out_idle: assert property (
      $rose(rstn) |-> tx_pin && rdata == 8'h00)
      else $error("outputs not idle after reset");
   a_rdata_holds: assert property (
      (cs_n || rd_n) |=> $stable(rdata))
      else $error("read data moved without a read");
   a_scratch_read: assert property (
      s_read(OFS_SCRATCH) |=> rdata == scr_shadow)
      else $error("scratch read mismatch");
   a_lctl_read: assert property (
      s_read(OFS_LCTL) |=> rdata == lctl_shadow)
      else $error("line control read mismatch");
   a_div_low_read: assert property (
      s_read(OFS_HOLD) ##0 lctl_shadow[LCTL_DLAB] |=> rdata == dll_shadow)
      else $error("divisor low read mismatch");
   a_mstat_zero: assert property (
      s_read(OFS_MSTAT) |=> rdata == 8'h00)
      else $error("modem status not zero");
   a_lstat_empty_order: assert property (
      s_read(OFS_LSTAT) |=> !rdata[6] || rdata[5])
      else $error("shifter empty without holding empty");
   a_isr_low_bits: assert property (
      s_read(OFS_FIFO) |=> rdata[5:0] == 6'h01)
      else $error("interrupt status low bits wrong");
   a_start_bit_len: assert property (
      s_tx_start |-> (!tx_pin)[*8])
      else $error("start bit too short");
endmodule
bind uart_channel uart_channel_chk uart_channel_chk_i (.clk(clk),
   .rstn(rstn), .cs_n(cs_n), .addr(addr), .wr_n(wr_n), .rd_n(rd_n),
   .wdata(wdata), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin));

// ==== verification/uart_far_end.sv ====
// Remote serial transceiver: sends frames, decodes the channel output.
// Assumes the channel runs 16 clk per bit (divisor of one), 8N1.
`timescale 1ns/10ps
module uart_far_end
#(
   parameter int BIT_CLKS = 16
)
(
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] got_q[$];
   logic [7:0] shift;
   // Line idles at mark between frames
   initial line_out = 1'b1;
   // One frame LSB first; a low stop bit gives a framing error
   task automatic send(input logic [7:0] data, input logic stop_bit);
      @(negedge clk);
      line_out = 1'b0;
      repeat (BIT_CLKS) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
         line_out = data[i];
         repeat (BIT_CLKS) @(negedge clk);
      end
      line_out = stop_bit;
      repeat (BIT_CLKS) @(negedge clk);
      line_out = 1'b1;
   endtask
   // Short low pulse that must not pass as a start bit
   task automatic pulse(input int clks);
      @(negedge clk);
      line_out = 1'b0;
      repeat (clks) @(negedge clk);
      line_out = 1'b1;
   endtask
   // Receiver: validate start at mid-bit, then sample bit centres
   initial
   begin
      forever
      begin
         @(negedge line_in);
         repeat (BIT_CLKS / 2) @(posedge clk);
         if (!line_in)
         begin
            for (int i = 0; i < 8; i++)
            begin
               repeat (BIT_CLKS) @(posedge clk);
               shift[i] = line_in;
            end
            repeat (BIT_CLKS) @(posedge clk);
            got_q.push_back(shift);
         end
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for one serial channel and its far end.
// Assumes reset divisor of one, so one bit lasts 16 clk.
`timescale 1ns/10ps
module tb_top
   import uart_regs_pkg::*;
;
   typedef struct packed {
      logic do_wr;
      logic [2:0] ofs;
      logic [7:0] data;
      logic [7:0] exp;
   } row_s;
   logic clk;
   logic rstn;
   logic cs_n;
   logic [2:0] addr;
   logic wr_n;
   logic rd_n;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rx_pin;
   logic tx_pin;
   logic [7:0] rd_val;
   int fail_count = 0;
   int cmp_count = 0;
   row_s rows[12] = '{'{1'b1, 3'h7, 8'ha5, 8'ha5}, '{1'b1, 3'h7, 8'h5a, 8'h5a},
      '{1'b1, 3'h4, 8'h03, 8'h03}, '{1'b1, 3'h1, 8'h0f, 8'h0f},
      '{1'b1, 3'h5, 8'h00, 8'h60}, '{1'b1, 3'h3, 8'h83, 8'h83},
      '{1'b1, 3'h0, 8'h02, 8'h02}, '{1'b1, 3'h1, 8'h00, 8'h00},
      '{1'b1, 3'h0, 8'h01, 8'h01}, '{1'b1, 3'h3, 8'h03, 8'h03},
      '{1'b0, 3'h1, 8'h00, 8'h0f}, '{1'b0, 3'h6, 8'h00, 8'h00}};
   logic [2:0] rst_ofs[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   logic [7:0] rst_exp[6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hff};
   uart_channel uart_channel_i (.clk(clk), .rstn(rstn), .cs_n(cs_n),
      .addr(addr), .wr_n(wr_n), .rd_n(rd_n), .wdata(wdata), .rdata(rdata),
      .rx_pin(rx_pin), .tx_pin(tx_pin));
   uart_far_end uart_far_end_i (.clk(clk), .line_in(tx_pin),
      .line_out(rx_pin));
   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [2:0] ofs, input logic [7:0] data,
      input logic sel_n = 1'b0);
      @(negedge clk);
      cs_n = sel_n;
      addr = ofs;
      wdata = data;
      wr_n = 1'b0;
      @(negedge clk);
      wr_n = 1'b1;
      cs_n = 1'b1;
   endtask
   // Read data is ready one clk after the read is taken
   task automatic rd(input logic [2:0] ofs, output logic [7:0] val);
      @(negedge clk);
      cs_n = 1'b0;
      addr = ofs;
      rd_n = 1'b0;
      repeat (2) @(negedge clk);
      val = rdata;
      rd_n = 1'b1;
      cs_n = 1'b1;
   endtask
   // Poll line status until all bits of mask are set, bounded
   task automatic wait_flag(input logic [7:0] mask);
      int n;
      n = 0;
      rd(OFS_LSTAT, rd_val);
      while ((rd_val & mask) !== mask && n < 2000)
      begin
         rd(OFS_LSTAT, rd_val);
         n++;
      end
      check("status flag", rd_val & mask, mask);
   endtask
   // Watchdog far beyond the expected run of some 4000 clk
   initial
   begin
      repeat (40000) @(posedge clk);
      fail_count++;
      complete_run;
   end
   // Main sequence
   initial
   begin
      rstn = 1'b0;
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].do_wr)
            wr(rows[i].ofs, rows[i].data);
         rd(rows[i].ofs, rd_val);
         check("register", rd_val, rows[i].exp);
      end
      wr(OFS_SCRATCH, 8'h00, 1'b1);
      rd(OFS_SCRATCH, rd_val);
      check("unselected write", rd_val, 8'h5a);
      // Second char enters holding while the first shifts; third dropped
      wr(OFS_HOLD, 8'h96);
      wait_flag(8'h20);
      wr(OFS_HOLD, 8'h3c);
      wr(OFS_HOLD, 8'hff);
      rd(OFS_LSTAT, rd_val);
      check("holding full", rd_val & 8'h60, 8'h00);
      wait_flag(8'h40);
      check("idle status", rd_val, 8'h60);
      check("tx count", 8'(uart_far_end_i.got_q.size()), 8'h02);
      check("tx first", uart_far_end_i.got_q[0], 8'h96);
      check("tx second", uart_far_end_i.got_q[1], 8'h3c);
      uart_far_end_i.got_q.delete();
      // FIFO mode: fill shifter and all sixteen places
      wr(OFS_FIFO, 8'h07);
      for (int i = 0; i < 17; i++)
         wr(OFS_HOLD, 8'(i + 1));
      rd(OFS_LSTAT, rd_val);
      check("tx fifo full", rd_val & 8'h20, 8'h00);
      wait_flag(8'h20);
      wait_flag(8'h40);
      check("fifo count", 8'(uart_far_end_i.got_q.size()), 8'h11);
      check("fifo last", uart_far_end_i.got_q[16], 8'h11);
      // False start, then two chars and a break
      uart_far_end_i.pulse(4);
      repeat (200) @(negedge clk);
      rd(OFS_LSTAT, rd_val);
      check("false start", rd_val & 8'h01, 8'h00);
      uart_far_end_i.send(8'h5a, 1'b1);
      uart_far_end_i.send(8'ha7, 1'b1);
      uart_far_end_i.send(8'h00, 1'b0);
      rd(OFS_HOLD, rd_val);
      check("rx oldest", rd_val, 8'h5a);
      rd(OFS_HOLD, rd_val);
      check("rx next", rd_val, 8'ha7);
      rd(OFS_LSTAT, rd_val);
      check("rx break", rd_val & 8'h99, 8'h99);
      rd(OFS_HOLD, rd_val);
      check("rx break data", rd_val, 8'h00);
      rd(OFS_LSTAT, rd_val);
      check("rx drained", rd_val & 8'h01, 8'h00);
      // Reset in mid-run restores the documented values
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      foreach (rst_ofs[i])
      begin
         rd(rst_ofs[i], rd_val);
         check("reset value", rd_val, rst_exp[i]);
      end
      complete_run;
   end
endmodule
